// ===== logic/csp_pkg.sv
package csp_pkg;
   // Status bit positions
   localparam int ST_CARRY     = 0;
   localparam int ST_HALF      = 1;
   localparam int ST_ZERO      = 2;
   localparam int ST_SLEEP_N   = 3;
   localparam int ST_WDT_N     = 4;
   localparam int ST_RSVD      = 5;
   localparam int ST_CMP_WAKE  = 6;
   localparam int ST_PIN_WAKE  = 7;
   // Option bit positions, plus the trim bit for the quarter-clock output
   localparam int OPT_WAKE_N   = 7;
   localparam int OPT_PULL_N   = 6;
   localparam int OPT_CLKSEL   = 5;
   localparam int OPT_EDGE     = 4;
   localparam int OPT_PSA      = 3;
   localparam int OPT_RATE_HI  = 2;
   localparam int TRIM_QOUT    = 0;
   // Reset values
   localparam logic [7:0] OPTION_RST  = 8'hFF;
   localparam logic [7:0] TRIM_RST    = 8'hFE;
   localparam logic       RSVD_VALUE  = 1'b0;
   localparam logic [7:0] ZERO_BYTE   = 8'h00;
   // Time-out and power-down flags up, everything else low
   localparam logic [7:0] STATUS_RST  = 8'h18;
   // Port pins carrying wake and pull-up: 0, 1 and 3
   localparam logic [3:0] WAKE_PINS   = 4'hB;
   localparam int         QOUT_PIN    = 2;

   typedef enum logic [2:0] {
      CSP_OP_NONE = 3'b000,
      CSP_OP_ADD  = 3'b001,
      CSP_OP_SUB  = 3'b010,
      CSP_OP_RRF  = 3'b011,
      CSP_OP_RLF  = 3'b100,
      CSP_OP_LOGIC = 3'b101
   } csp_alu_op_t;

   typedef enum logic [2:0] {
      CSP_PC_STEP = 3'b000,
      CSP_PC_JUMP = 3'b001,
      CSP_PC_CALL = 3'b010,
      CSP_PC_LOW  = 3'b011,
      CSP_PC_RET  = 3'b100
   } csp_pc_op_t;

   // ALU result and operands from the execute stage
   typedef struct packed {
      csp_alu_op_t op;
      logic [7:0]  a;
      logic [7:0]  b;
      logic [7:0]  res;
      logic        shift_out;
   } csp_alu_t;

   // Hardware events to the status register
   typedef struct packed {
      logic por;
      logic other_reset;
      logic pin_wake_reset;
      logic cmp_wake_reset;
      logic kick_dog;
      logic sleep;
      logic wdt_timeout;
   } csp_evt_t;

   // Option fields seen by timer and watchdog
   typedef struct packed {
      logic       tmr_clk_select;
      logic       tmr_edge_select;
      logic       prescaler_assign;
      logic [2:0] prescale_rate;
   } csp_opt_t;
endpackage : csp_pkg

// ===== logic/csp_pc_stack.sv
`timescale 1ns/10ps
`default_nettype none
module csp_pc_stack #(
   parameter int PC_W = 9,
   parameter int STK_W = 8
) (
   input  wire logic               mclk,
   input  wire logic               reset,
   input  wire csp_pkg::csp_pc_op_t pc_op,
   input  wire logic [8:0]         target,
   output logic [PC_W-1:0]         pc_ff,
   output logic [STK_W-1:0]        stack1_ff,
   output logic [STK_W-1:0]        stack2_ff
);
   if (PC_W < 9 || PC_W > 10 || STK_W != PC_W - 1) begin : g_bad_width
      $error("csp_pc_stack: unsupported width");
   end

   logic [PC_W-1:0]  nxt_pc;
   logic [STK_W-1:0] nxt_stack1;
   logic [STK_W-1:0] nxt_stack2;
   logic [PC_W-1:0]  pc_inc;
   logic [PC_W-1:0]  mask;

   // Upper half of counter space aliases the implemented words
   always_comb begin
      mask       = {1'b0, {(PC_W-1){1'b1}}};
      pc_inc     = (pc_ff + 1'b1) & mask;
      nxt_pc     = pc_inc;
      nxt_stack1 = stack1_ff;
      nxt_stack2 = stack2_ff;
      unique case (pc_op)
         csp_pkg::CSP_PC_STEP: nxt_pc = pc_inc;
         csp_pkg::CSP_PC_JUMP: nxt_pc = PC_W'(target) & mask;
         csp_pkg::CSP_PC_CALL: begin
            nxt_pc     = PC_W'({1'b0, target[7:0]}) & mask;
            nxt_stack2 = stack1_ff;
            nxt_stack1 = pc_inc[STK_W-1:0];
         end
         csp_pkg::CSP_PC_LOW:  nxt_pc = PC_W'({1'b0, target[7:0]}) & mask;
         csp_pkg::CSP_PC_RET:  begin
            nxt_pc     = PC_W'(stack1_ff);
            nxt_stack1 = stack2_ff;
         end
         default: nxt_pc = pc_inc;
      endcase
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pc_ff     <= '1;
         stack1_ff <= '0;
         stack2_ff <= '0;
      end else begin
         pc_ff     <= nxt_pc;
         stack1_ff <= nxt_stack1;
         stack2_ff <= nxt_stack2;
      end
   end

   a_call_push: assert property (@(posedge mclk) disable iff (reset)
      pc_op == csp_pkg::CSP_PC_CALL |=> stack2_ff == $past(stack1_ff)
         && pc_ff[8] == 1'b0)
      else $error("call did not push");
   a_ret_pop: assert property (@(posedge mclk) disable iff (reset)
      pc_op == csp_pkg::CSP_PC_RET |=> pc_ff == PC_W'($past(stack1_ff))
         && stack1_ff == $past(stack2_ff))
      else $error("return did not pop");
   a_pc_step: assert property (@(posedge mclk) disable iff (reset)
      pc_op == csp_pkg::CSP_PC_STEP && pc_ff != mask |=> pc_ff == $past(pc_ff) + 1'b1)
      else $error("counter did not step");
endmodule : csp_pc_stack
`default_nettype wire

// ===== logic/csp_core_regs.sv
`timescale 1ns/10ps
`default_nettype none
module csp_core_regs #(
   parameter int PC_W = 9,
   parameter int STK_W = 8
) (
   input  wire logic                 mclk,
   input  wire logic                 reset,
   input  wire csp_pkg::csp_evt_t    evt,
   input  wire csp_pkg::csp_alu_t    alu,
   input  wire logic                 status_wr,
   input  wire logic [7:0]           status_wdata,
   input  wire logic                 option_wr,
   input  wire logic                 trim_wr,
   input  wire logic [7:0]           acc,
   input  wire logic [7:0]           literal,
   input  wire logic                 ret_instr,
   input  wire csp_pkg::csp_pc_op_t  pc_op,
   input  wire logic [8:0]           target,
   input  wire logic [3:0]           direction_ctl,
   input  wire logic                 internal_osc_q,
   output logic [7:0]                status_ff,
   output logic [7:0]                trim_ff,
   output logic [7:0]                acc_load_ff,
   output logic                      acc_load_vld_ff,
   output csp_pkg::csp_opt_t         opt,
   output logic                      tmr_ext_override,
   output logic [3:0]                pin_wake_en,
   output logic [3:0]                pin_pullup_en,
   output logic                      port_pin2_quarter_en,
   output logic                      port_pin2_quarter_out,
   output logic signed [6:0]         trim_adjust,
   output logic [7:0]                tmr_div_log2,
   output logic [7:0]                wdt_div_log2,
   output logic [PC_W-1:0]           pc,
   output logic [STK_W-1:0]          stack1,
   output logic [STK_W-1:0]          stack2
);
   logic [7:0] option_ff;
   logic [7:0] nxt_status;
   logic [7:0] nxt_option;
   logic [7:0] nxt_trim;
   logic [7:0] nxt_acc_load;
   logic       nxt_acc_load_vld;
   logic       flag_op;
   logic [4:0] low_sum;
   logic [8:0] full_sum;

   // Status: arithmetic flags, wake cause and watchdog/sleep flags
   always_comb begin
      nxt_status = status_ff;
      low_sum    = 5'h00;
      full_sum   = 9'h000;
      flag_op    = (alu.op != csp_pkg::CSP_OP_NONE);
      // Plain writes touch only writable bits
      if (status_wr) begin
         nxt_status[csp_pkg::ST_PIN_WAKE] = status_wdata[csp_pkg::ST_PIN_WAKE];
         nxt_status[csp_pkg::ST_CMP_WAKE] = status_wdata[csp_pkg::ST_CMP_WAKE];
         if (!flag_op) begin
            nxt_status[csp_pkg::ST_ZERO:csp_pkg::ST_CARRY] = status_wdata[2:0];
         end
      end
      // Flag results win over the written value
      unique case (alu.op)
         csp_pkg::CSP_OP_ADD: begin
            low_sum  = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};
            full_sum = {1'b0, alu.a} + {1'b0, alu.b};
            nxt_status[csp_pkg::ST_HALF]  = low_sum[4];
            nxt_status[csp_pkg::ST_CARRY] = full_sum[8];
            nxt_status[csp_pkg::ST_ZERO]  = (alu.res == csp_pkg::ZERO_BYTE);
         end
         csp_pkg::CSP_OP_SUB: begin
            // Two's complement add: carry out equals no borrow
            low_sum  = {1'b0, alu.a[3:0]} + {1'b0, ~alu.b[3:0]} + 5'h01;
            full_sum = {1'b0, alu.a} + {1'b0, ~alu.b} + 9'h001;
            nxt_status[csp_pkg::ST_HALF]  = low_sum[4];
            nxt_status[csp_pkg::ST_CARRY] = full_sum[8];
            nxt_status[csp_pkg::ST_ZERO]  = (alu.res == csp_pkg::ZERO_BYTE);
         end
         csp_pkg::CSP_OP_RRF,
         csp_pkg::CSP_OP_RLF: nxt_status[csp_pkg::ST_CARRY] = alu.shift_out;
         csp_pkg::CSP_OP_LOGIC: nxt_status[csp_pkg::ST_ZERO] = (alu.res == csp_pkg::ZERO_BYTE);
         csp_pkg::CSP_OP_NONE: ;
         default: ;
      endcase
      // Hardware events last so they beat any write
      if (evt.sleep) begin
         nxt_status[csp_pkg::ST_WDT_N]   = 1'b1;
         nxt_status[csp_pkg::ST_SLEEP_N] = 1'b0;
      end
      if (evt.kick_dog) begin
         nxt_status[csp_pkg::ST_WDT_N]   = 1'b1;
         nxt_status[csp_pkg::ST_SLEEP_N] = 1'b1;
      end
      if (evt.wdt_timeout) begin
         nxt_status[csp_pkg::ST_WDT_N] = 1'b0;
      end
      if (evt.por || evt.other_reset || evt.pin_wake_reset || evt.cmp_wake_reset) begin
         nxt_status[csp_pkg::ST_PIN_WAKE] = evt.pin_wake_reset;
         nxt_status[csp_pkg::ST_CMP_WAKE] = evt.cmp_wake_reset;
      end
      if (evt.por) begin
         nxt_status[csp_pkg::ST_WDT_N]   = 1'b1;
         nxt_status[csp_pkg::ST_SLEEP_N] = 1'b1;
      end
      nxt_status[csp_pkg::ST_RSVD] = csp_pkg::RSVD_VALUE;
   end

   // Option, trim and the literal handed back on return
   always_comb begin
      nxt_option       = option_ff;
      nxt_trim         = trim_ff;
      nxt_acc_load     = acc_load_ff;
      nxt_acc_load_vld = 1'b0;
      if (option_wr) begin
         nxt_option = acc;
      end
      if (trim_wr) begin
         nxt_trim = acc;
      end
      if (ret_instr) begin
         nxt_acc_load     = literal;
         nxt_acc_load_vld = 1'b1;
      end
      // Other resets restore option even without the async line
      if (evt.por || evt.other_reset || evt.pin_wake_reset || evt.cmp_wake_reset) begin
         nxt_option = csp_pkg::OPTION_RST;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         // Arithmetic flags undefined by spec; zero chosen
         status_ff       <= csp_pkg::STATUS_RST;
         option_ff       <= csp_pkg::OPTION_RST;
         trim_ff         <= csp_pkg::TRIM_RST;
         acc_load_ff     <= 8'h00;
         acc_load_vld_ff <= 1'b0;
      end else begin
         status_ff       <= nxt_status;
         option_ff       <= nxt_option;
         trim_ff         <= nxt_trim;
         acc_load_ff     <= nxt_acc_load;
         acc_load_vld_ff <= nxt_acc_load_vld;
      end
   end

   // Decoded option fields
   always_comb begin
      opt.tmr_clk_select   = option_ff[csp_pkg::OPT_CLKSEL];
      opt.tmr_edge_select  = option_ff[csp_pkg::OPT_EDGE];
      opt.prescaler_assign = option_ff[csp_pkg::OPT_PSA];
      opt.prescale_rate    = option_ff[csp_pkg::OPT_RATE_HI:0];
      tmr_ext_override     = option_ff[csp_pkg::OPT_CLKSEL];
      // Unassigned side sees no division
      tmr_div_log2 = option_ff[csp_pkg::OPT_PSA] ? 8'h00
                   : {5'h00, option_ff[2:0]} + 8'h01;
      wdt_div_log2 = option_ff[csp_pkg::OPT_PSA] ? {5'h00, option_ff[2:0]}
                   : 8'h00;
      trim_adjust  = signed'(trim_ff[7:1]);
      port_pin2_quarter_en  = trim_ff[csp_pkg::TRIM_QOUT];
      port_pin2_quarter_out = trim_ff[csp_pkg::TRIM_QOUT] & internal_osc_q;
   end

   // Per-pin wake and pull-up gating by direction
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pin
         assign pin_wake_en[gi] = csp_pkg::WAKE_PINS[gi] & direction_ctl[gi]
                                & ~option_ff[csp_pkg::OPT_WAKE_N];
         assign pin_pullup_en[gi] = csp_pkg::WAKE_PINS[gi] & direction_ctl[gi]
                                  & ~option_ff[csp_pkg::OPT_PULL_N];
      end
   endgenerate

   // Stack sized per variant
   csp_pc_stack #(.PC_W(PC_W), .STK_W(STK_W)) u_pc (
      .mclk      (mclk),
      .reset     (reset),
      .pc_op     (pc_op),
      .target    (target),
      .pc_ff     (pc),
      .stack1_ff (stack1),
      .stack2_ff (stack2)
   );

   a_flag_override: assert property (@(posedge mclk) disable iff (reset)
      status_wr && alu.op == csp_pkg::CSP_OP_LOGIC && alu.res == csp_pkg::ZERO_BYTE
      && !evt.por && !evt.other_reset |=> status_ff[csp_pkg::ST_ZERO])
      else $error("zero flag took written value");
   a_guard_bits: assert property (@(posedge mclk) disable iff (reset)
      status_wr && !evt.sleep && !evt.kick_dog && !evt.wdt_timeout && !evt.por
      |=> status_ff[4:3] == $past(status_ff[4:3]))
      else $error("guarded flags changed by write");
   a_wake_cause: assert property (@(posedge mclk) disable iff (reset)
      evt.pin_wake_reset |=> status_ff[csp_pkg::ST_PIN_WAKE])
      else $error("pin wake cause lost");
   a_timeout_clr: assert property (@(posedge mclk) disable iff (reset)
      evt.wdt_timeout && !evt.por |=> !status_ff[csp_pkg::ST_WDT_N])
      else $error("timeout not recorded");
   a_sleep_clr: assert property (@(posedge mclk) disable iff (reset)
      evt.sleep && !evt.kick_dog && !evt.por |=> !status_ff[csp_pkg::ST_SLEEP_N])
      else $error("sleep not recorded");
   a_option_load: assert property (@(posedge mclk) disable iff (reset)
      option_wr && !evt.por && !evt.other_reset && !evt.pin_wake_reset
      && !evt.cmp_wake_reset |=> opt.prescale_rate == $past(acc[2:0]))
      else $error("option not loaded");
   a_rsvd_const: assert property (@(posedge mclk) disable iff (reset)
      status_wr ##1 1'b1 |-> status_ff[csp_pkg::ST_RSVD] == csp_pkg::RSVD_VALUE)
      else $error("reserved bit changed");
   a_out_pin_gate: assert property (@(posedge mclk) disable iff (reset)
      !direction_ctl[0] |-> !pin_wake_en[0] && !pin_pullup_en[0])
      else $error("output pin kept wake or pull-up");
   a_ret_literal: assert property (@(posedge mclk) disable iff (reset)
      ret_instr |=> acc_load_vld_ff && acc_load_ff == $past(literal))
      else $error("literal not returned");

   // Watchdog, power-down and wake flags are tied to their events, zero to ADD and carry to rotates; option to the resets
   a_kick_flags: assert property (@(posedge mclk) disable iff (reset)
      evt.kick_dog && !evt.wdt_timeout
      |=> status_ff[csp_pkg::ST_WDT_N] && status_ff[csp_pkg::ST_SLEEP_N])
      else $error("kick did not raise flags");
   a_por_flags: assert property (@(posedge mclk) disable iff (reset)
      evt.por && !evt.pin_wake_reset && !evt.cmp_wake_reset
      |=> status_ff[csp_pkg::ST_WDT_N] && status_ff[csp_pkg::ST_SLEEP_N]
      && !status_ff[csp_pkg::ST_PIN_WAKE] && !status_ff[csp_pkg::ST_CMP_WAKE])
      else $error("power-up flags wrong");
   a_cmp_cause: assert property (@(posedge mclk) disable iff (reset)
      evt.cmp_wake_reset |=> status_ff[csp_pkg::ST_CMP_WAKE])
      else $error("comparator wake cause lost");
   a_other_clear: assert property (@(posedge mclk) disable iff (reset)
      evt.other_reset && !evt.pin_wake_reset && !evt.cmp_wake_reset
      |=> !status_ff[csp_pkg::ST_PIN_WAKE] && !status_ff[csp_pkg::ST_CMP_WAKE])
      else $error("wake cause kept after other reset");
   a_option_reset: assert property (@(posedge mclk) disable iff (reset)
      evt.por || evt.other_reset || evt.pin_wake_reset || evt.cmp_wake_reset
      |=> option_ff == csp_pkg::OPTION_RST)
      else $error("option not restored by reset");
   a_zero_add: assert property (@(posedge mclk) disable iff (reset)
      alu.op == csp_pkg::CSP_OP_ADD && alu.res == csp_pkg::ZERO_BYTE
      |=> status_ff[csp_pkg::ST_ZERO])
      else $error("zero result not flagged");
   a_rot_carry: assert property (@(posedge mclk) disable iff (reset)
      alu.op == csp_pkg::CSP_OP_RRF || alu.op == csp_pkg::CSP_OP_RLF
      |=> status_ff[csp_pkg::ST_CARRY] == $past(alu.shift_out))
      else $error("rotate carry wrong");
   // One prescaler only, so at most one side may divide
   a_prescale_one: assert property (@(posedge mclk) disable iff (reset)
      tmr_div_log2 == csp_pkg::ZERO_BYTE || wdt_div_log2 == csp_pkg::ZERO_BYTE)
      else $error("prescaler on both sides");
   a_wake_off: assert property (@(posedge mclk) disable iff (reset)
      option_ff[csp_pkg::OPT_WAKE_N] |-> pin_wake_en == 4'h0)
      else $error("wake enabled while disabled");
   a_pin2_never: assert property (@(posedge mclk) disable iff (reset)
      ((pin_wake_en | pin_pullup_en) & ~csp_pkg::WAKE_PINS) == 4'h0)
      else $error("wake or pull-up on unsupported pin");
   a_quarter_off: assert property (@(posedge mclk) disable iff (reset)
      !trim_ff[csp_pkg::TRIM_QOUT] |-> !port_pin2_quarter_out)
      else $error("quarter clock leaked onto pin");
   a_trim_load: assert property (@(posedge mclk) disable iff (reset)
      trim_wr |=> trim_ff == $past(acc))
      else $error("trim not loaded");
endmodule : csp_core_regs
`default_nettype wire

// ===== verif/csp_core_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, g, e) chk(n, 32'(e), 32'(g))
module csp_core_regs_tb_top;
   logic                   mclk;
   logic                   reset;
   csp_pkg::csp_evt_t      evt;
   csp_pkg::csp_alu_t      alu;
   logic                   status_wr;
   logic [7:0]             status_wdata;
   logic                   option_wr;
   logic                   trim_wr;
   logic [7:0]             acc;
   logic [7:0]             literal;
   logic                   ret_instr;
   csp_pkg::csp_pc_op_t    pc_op;
   logic [8:0]             target;
   logic [3:0]             direction_ctl;
   logic                   internal_osc_q;
   logic [7:0]             status_ff, trim_ff, acc_load_ff, tmr_div_log2, wdt_div_log2;
   logic                   acc_load_vld_ff, tmr_ext_override, q_en, q_out;
   csp_pkg::csp_opt_t      opt;
   logic [3:0]             pin_wake_en, pin_pullup_en;
   logic signed [6:0]      trim_adjust;
   logic [8:0]             pc;
   logic [7:0]             stack1, stack2;
   int                     mismatches = 0;
   int                     check_count = 0;

   csp_core_regs uut (.mclk(mclk), .reset(reset), .evt(evt), .alu(alu), .status_wr(status_wr),
      .status_wdata(status_wdata), .option_wr(option_wr), .trim_wr(trim_wr), .acc(acc),
      .literal(literal), .ret_instr(ret_instr), .pc_op(pc_op), .target(target),
      .direction_ctl(direction_ctl), .internal_osc_q(internal_osc_q), .status_ff(status_ff),
      .trim_ff(trim_ff), .acc_load_ff(acc_load_ff), .acc_load_vld_ff(acc_load_vld_ff),
      .opt(opt), .tmr_ext_override(tmr_ext_override), .pin_wake_en(pin_wake_en),
      .pin_pullup_en(pin_pullup_en), .port_pin2_quarter_en(q_en),
      .port_pin2_quarter_out(q_out), .trim_adjust(trim_adjust), .tmr_div_log2(tmr_div_log2),
      .wdt_div_log2(wdt_div_log2), .pc(pc), .stack1(stack1), .stack2(stack2));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s expected %0h seen %0h", n, e, g);
      end
   endtask : chk

   // Every control is assigned once per call, so back-to-back cycles never double-drive
   task automatic ctl(input logic sw = 1'b0, input logic ow = 1'b0, input logic tw = 1'b0,
      input logic rt = 1'b0, input csp_pkg::csp_pc_op_t p = csp_pkg::CSP_PC_STEP,
      input csp_pkg::csp_evt_t e = '0, input csp_pkg::csp_alu_t a = '0);
      status_wr = sw;
      option_wr = ow;
      trim_wr = tw;
      ret_instr = rt;
      pc_op = p;
      evt = e;
      alu = a;
   endtask : ctl

   task automatic step;
      @(posedge mclk);
      #1;
   endtask : step

   task automatic t_reset_vals;
      `CHK("status_rst", status_ff, 8'h18);
      `CHK("opt_rst", opt, 6'h3F);
      `CHK("wake_rst", pin_wake_en, 4'h0);
      `CHK("trim_rst", trim_ff, 8'hFE);
      `CHK("q_en_rst", q_en, 1'b0);
      `CHK("pc_rst", pc, 9'h1FF);
      `CHK("stk_rst", {stack1, stack2}, 16'h0000);
   endtask : t_reset_vals

   task automatic t_pc_stack;
      ctl();
      step;
      `CHK("pc_wrap", pc, 9'h000);
      target = 9'h0A3;
      ctl(.p(csp_pkg::CSP_PC_JUMP));
      step;
      `CHK("pc_jump", pc, 9'h0A3);
      ctl();
      step;
      `CHK("pc_step", pc, 9'h0A4);
      target = 9'h155;
      ctl(.p(csp_pkg::CSP_PC_CALL));
      step;
      `CHK("call1", {pc, stack1, stack2}, 25'h055_A5_00);
      target = 9'h020;
      ctl(.p(csp_pkg::CSP_PC_CALL));
      step;
      `CHK("call2", {pc, stack1, stack2}, 25'h020_56_A5);
      target = 9'h030;
      ctl(.p(csp_pkg::CSP_PC_CALL));
      step;
      `CHK("call3", {pc, stack1, stack2}, 25'h030_21_56);
      literal = 8'h3C;
      ctl(.rt(1'b1), .p(csp_pkg::CSP_PC_RET));
      step;
      `CHK("ret1", {pc, stack1, acc_load_ff, acc_load_vld_ff}, {9'h021, 8'h56, 8'h3C, 1'b1});
      literal = 8'h5D;
      ctl(.rt(1'b1), .p(csp_pkg::CSP_PC_RET));
      step;
      `CHK("ret2", {pc, stack1, acc_load_ff, acc_load_vld_ff}, {9'h056, 8'h56, 8'h5D, 1'b1});
      ctl();
      step;
      `CHK("after_ret", {pc, acc_load_vld_ff}, 10'h0AE);
      target = 9'h1C7;
      ctl(.p(csp_pkg::CSP_PC_LOW));
      step;
      `CHK("pc_low", pc, 9'h0C7);
   endtask : t_pc_stack

   task automatic alu_case(input csp_pkg::csp_alu_t a, input logic wr, input logic [2:0] m,
      input logic [2:0] e);
      status_wdata = {5'h00, ~e};
      ctl(.sw(wr), .a(a));
      step;
      `CHK("flags", status_ff[2:0] & m, e & m);
   endtask : alu_case

   task automatic t_alu;
      alu_case({csp_pkg::CSP_OP_ADD, 8'h0F, 8'h01, 8'h10, 1'b0}, 1'b0, 3'h7, 3'b010);
      alu_case({csp_pkg::CSP_OP_ADD, 8'hFF, 8'h01, 8'h00, 1'b0}, 1'b1, 3'h7, 3'b111);
      alu_case({csp_pkg::CSP_OP_ADD, 8'h80, 8'h80, 8'h00, 1'b0}, 1'b0, 3'h7, 3'b101);
      alu_case({csp_pkg::CSP_OP_SUB, 8'h10, 8'h01, 8'h0F, 1'b0}, 1'b0, 3'h7, 3'b001);
      alu_case({csp_pkg::CSP_OP_SUB, 8'h01, 8'h02, 8'hFF, 1'b0}, 1'b1, 3'h7, 3'b000);
      alu_case({csp_pkg::CSP_OP_SUB, 8'h05, 8'h05, 8'h00, 1'b0}, 1'b0, 3'h7, 3'b111);
      alu_case({csp_pkg::CSP_OP_RRF, 8'h01, 8'h00, 8'h00, 1'b1}, 1'b0, 3'h1, 3'b001);
      alu_case({csp_pkg::CSP_OP_RLF, 8'h7F, 8'h00, 8'hFE, 1'b0}, 1'b0, 3'h1, 3'b000);
      alu_case({csp_pkg::CSP_OP_LOGIC, 8'h00, 8'h00, 8'h01, 1'b0}, 1'b1, 3'h4, 3'b000);
   endtask : t_alu

   task automatic t_option;
      for (int p = 0; p < 2; p++) begin
         for (int c = 0; c < 8; c++) begin
            acc = {4'hF, p[0], c[2:0]};
            ctl(.ow(1'b1));
            step;
            `CHK("tmr_div", tmr_div_log2, (p != 0) ? 0 : c + 1);
            `CHK("wdt_div", wdt_div_log2, (p != 0) ? c : 0);
            `CHK("psa", opt.prescaler_assign, p[0]);
         end
      end
      acc = 8'h5A;
      ctl(.ow(1'b1));
      step;
      `CHK("opt_5a", {opt, tmr_ext_override, pin_wake_en, pin_pullup_en},
           {6'h1A, 1'b0, 4'hB, 4'h0});
      direction_ctl = 4'h9;
      #1;
      `CHK("wake_dir", pin_wake_en, 4'h9);
      acc = 8'hA7;
      direction_ctl = 4'h6;
      ctl(.ow(1'b1));
      step;
      `CHK("opt_a7", {opt, tmr_ext_override, pin_wake_en, pin_pullup_en},
           {6'h27, 1'b1, 4'h0, 4'h2});
      `CHK("tmr_div8", tmr_div_log2, 8'h08);
   endtask : t_option

   task automatic t_trim;
      acc = 8'h81;
      internal_osc_q = 1'b1;
      ctl(.tw(1'b1));
      step;
      `CHK("trim_81", {trim_ff, 1'b0, trim_adjust, q_en, q_out},
           {8'h81, 1'b0, 7'h40, 1'b1, 1'b1});
      internal_osc_q = 1'b0;
      #1;
      `CHK("q_out_lo", q_out, 1'b0);
      acc = 8'h7E;
      ctl(.tw(1'b1));
      step;
      `CHK("trim_7e", {trim_adjust, q_en}, 8'h7E);
   endtask : t_trim

   task automatic t_events;
      ctl(.e(7'h02));
      step;
      `CHK("sleep", status_ff[4:3], 2'b10);
      status_wdata = 8'hFF;
      ctl(.sw(1'b1));
      step;
      `CHK("wr_ff", status_ff, 8'hD7);
      ctl(.e(7'h04));
      step;
      `CHK("kick", status_ff[4:3], 2'b11);
      ctl(.e(7'h01));
      step;
      `CHK("timeout", status_ff[4:3], 2'b01);
      ctl(.e(7'h10));
      step;
      `CHK("pin_wake", status_ff[7:6], 2'b10);
      ctl(.e(7'h08));
      step;
      `CHK("cmp_wake", status_ff[7:6], 2'b01);
      ctl(.e(7'h20));
      step;
      `CHK("other_rst", {status_ff[7:6], opt}, 8'h3F);
      ctl(.e(7'h40));
      step;
      `CHK("por", status_ff[7:3], 5'h03);
      status_wdata = 8'h00;
      ctl(.sw(1'b1));
      step;
      `CHK("wr_00", status_ff, 8'h18);
      ctl();
   endtask : t_events

   // Reset again while option, trim, counter and stack hold other values
   task automatic t_mid_reset;
      ctl();
      reset = 1'b1;
      #1;
      `CHK("mid_rst", {opt, trim_ff, pc}, {6'h3F, 8'hFE, 9'h1FF});
      `CHK("mid_stk", {stack1, stack2}, 16'h0000);
      step;
      reset = 1'b0;
      step;
      `CHK("mid_wrap", pc, 9'h000);
   endtask : t_mid_reset

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      #1000000;
      mismatches++;
      tally_and_finish();
   end

   initial begin
      reset = 1'b1;
      status_wdata = 8'h00;
      acc = 8'h00;
      literal = 8'h00;
      target = 9'h000;
      direction_ctl = 4'hF;
      internal_osc_q = 1'b0;
      ctl();
      repeat (5) @(posedge mclk);
      #1;
      t_reset_vals();
      reset = 1'b0;
      t_pc_stack();
      t_alu();
      t_option();
      t_trim();
      t_mid_reset();
      t_events();
      step;
      tally_and_finish();
   end
endmodule : csp_core_regs_tb_top
`default_nettype wire
